// ==== design/apb_reg_port.sv ====
`timescale 1ns/1ns
module apb_reg_port (
	input  wire logic                            pclk,
	input  wire logic                            presetn,
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire sys_integ_pkg::apb_req_t         req,
	input  wire logic [sys_integ_pkg::REG_W-1:0] rd_break,
	input  wire logic [sys_integ_pkg::REG_W-1:0] rd_cause,
	input  wire logic [sys_integ_pkg::REG_W-1:0] rd_ctrl,
	output logic                                 pready,
	output logic                                 pslverr,
	output logic [sys_integ_pkg::DATA_W-1:0]     prdata,
	output sys_integ_pkg::reg_sel_t              sel,
	output logic                                 access,
	output logic                                 mapped
);
	import sys_integ_pkg::*;

	logic [DATA_W-1:0] next_prdata;

	always_comb begin
		sel = SEL_NONE;
		mapped = 1'b1;
		unique case (req.addr)
			ADDR_BREAK_STATUS: sel = SEL_BREAK;
			ADDR_RESET_CAUSE:  sel = SEL_CAUSE;
			ADDR_BREAK_CTRL:   sel = SEL_CTRL;
			default:           mapped = 1'b0;
		endcase
	end

	// zero wait states: access phase always completes
	assign access  = psel & penable;
	assign pready  = access;
	assign pslverr = access & ~mapped;

	// read data sampled in setup so the access edge can clear what was shown
	always_comb begin
		next_prdata = prdata;
		if (psel && !penable) begin
			next_prdata = DATA_ZERO;
			unique case (sel)
				SEL_BREAK: next_prdata[REG_W-1:0] = rd_break;
				SEL_CAUSE: next_prdata[REG_W-1:0] = rd_cause;
				SEL_CTRL:  next_prdata[REG_W-1:0] = rd_ctrl;
				SEL_NONE:  next_prdata = DATA_ZERO;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= DATA_ZERO;
		end else begin
			prdata <= next_prdata;
		end
	end

endmodule

// ==== design/reset_and_break_status_regs.sv ====
`timescale 1ns/1ns
module reset_and_break_status_regs (
	input  wire logic                                 pclk,
	input  wire logic                                 presetn,
	input  wire logic                                 psel,
	input  wire logic                                 penable,
	input  wire logic                                 pwrite,
	input  wire logic [sys_integ_pkg::ADDR_W-1:0]     paddr,
	input  wire logic [sys_integ_pkg::DATA_W-1:0]     pwdata,
	output logic                                      pready,
	output logic                                      pslverr,
	output logic [sys_integ_pkg::DATA_W-1:0]          prdata,
	input  wire logic                                 break_exit_event,
	input  wire sys_integ_pkg::reset_src_t            reset_src,
	input  wire logic                                 break_state,
	output logic                                      break_clear_enable,
	output logic                                      clear_allow,
	input  wire logic [sys_integ_pkg::GUARD_CH-1:0]   step_first,
	input  wire logic [sys_integ_pkg::GUARD_CH-1:0]   step_second,
	output logic [sys_integ_pkg::GUARD_CH-1:0]        flag_clear
);
	import sys_integ_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// bus front end

	apb_req_t          req;
	reg_sel_t          sel;
	logic              access;
	logic              mapped;
	logic [REG_W-1:0]  break_status;
	logic [REG_W-1:0]  reset_cause;
	logic [REG_W-1:0]  break_ctrl;
	logic [REG_W-1:0]  shown_cause;
	logic              wr_break;
	logic              wr_ctrl;
	logic              rd_cause;
	logic [REG_W-1:0]  wbyte;

	// one driver for the whole carrier rather than one per field
	assign req = '{addr: paddr, write: pwrite, wdata: pwdata};

	apb_reg_port u_port (
		.pclk     (pclk),
		.presetn  (presetn),
		.psel     (psel),
		.penable  (penable),
		.req      (req),
		.rd_break (break_status),
		.rd_cause (reset_cause),
		.rd_ctrl  (break_ctrl),
		.pready   (pready),
		.pslverr  (pslverr),
		.prdata   (prdata),
		.sel      (sel),
		.access   (access),
		.mapped   (mapped)
	);

	// upper bytes of the write word are dropped: registers are one byte wide
	assign wbyte = pwdata[REG_W-1:0];

	assign wr_break = access & mapped & pwrite & (sel == SEL_BREAK);
	assign wr_ctrl  = access & mapped & pwrite & (sel == SEL_CTRL);
	assign rd_cause = access & mapped & ~pwrite & (sel == SEL_CAUSE);

	// the value returned is the value latched in setup
	assign shown_cause = prdata[REG_W-1:0];

	////////////////////////////////////////////////////////////////////////
	// break flag protection

	// outside break any clear is allowed; inside it only when enabled
	assign clear_allow = ~break_state | break_clear_enable;
	assign break_clear_enable = break_ctrl[BIT_BREAK_CLR_EN];

	////////////////////////////////////////////////////////////////////////
	// break control register

	logic [REG_W-1:0] next_break_ctrl;

	always_comb begin
		next_break_ctrl = break_ctrl;
		if (wr_ctrl) begin
			next_break_ctrl = REG_ZERO;
			next_break_ctrl[BIT_BREAK_CLR_EN] = wbyte[BIT_BREAK_CLR_EN];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			break_ctrl <= RST_BREAK_CTRL;
		end else begin
			break_ctrl <= next_break_ctrl;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reset source decode

	logic             any_reset_event;
	logic [REG_W-1:0] event_cause;

	always_comb begin
		event_cause = REG_ZERO;
		event_cause[BIT_PIN] = reset_src.pin;
		event_cause[BIT_WATCHDOG] = reset_src.watchdog;
		event_cause[BIT_ILL_OPCODE] = reset_src.illegal_opcode;
		// data accesses to an illegal address leave the flag alone
		event_cause[BIT_ILL_ADDRESS] = reset_src.illegal_address
			& reset_src.address_is_fetch;
		event_cause[BIT_LOW_VOLTAGE] = reset_src.low_voltage;
	end

	assign any_reset_event = |event_cause;

	////////////////////////////////////////////////////////////////////////
	// reset cause register

	logic [REG_W-1:0] next_reset_cause;
	logic [REG_W-1:0] read_clear_mask;

	// only the bits the reader saw are cleared, so a cause that lands
	// between setup and access is kept for the next read unless that bit was shown
	always_comb begin
		read_clear_mask = REG_ZERO;
		if (rd_cause && clear_allow) begin
			read_clear_mask = shown_cause;
		end
	end

	always_comb begin
		next_reset_cause = reset_cause & ~read_clear_mask;
		if (any_reset_event) begin
			// a new reset replaces the record of the previous one
			next_reset_cause = event_cause;
		end
	end

	// presetn is the power-on reset of this block
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_cause <= RST_RESET_CAUSE;
		end else begin
			reset_cause <= next_reset_cause;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// break exit status register

	logic [REG_W-1:0] next_break_status;
	logic             clear_break_exit;

	// only a written zero clears; a written one is ignored
	assign clear_break_exit = wr_break & ~wbyte[BIT_BREAK_EXIT]
		& clear_allow;

	always_comb begin
		next_break_status = break_status;
		if (clear_break_exit) begin
			next_break_status[BIT_BREAK_EXIT] = 1'b0;
		end
		if (any_reset_event) begin
			next_break_status = RST_BREAK_STATUS;
		end
		// an exit event beats a clear in the same cycle
		if (break_exit_event) begin
			next_break_status[BIT_BREAK_EXIT] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			break_status <= RST_BREAK_STATUS;
		end else begin
			break_status <= next_break_status;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// two-step clear guards for flags held elsewhere

	genvar g;
	generate
		for (g = 0; g < GUARD_CH; g++) begin : gen_guard
			two_step_clear_guard u_guard (
				.pclk        (pclk),
				.presetn     (presetn),
				.step_first  (step_first[g]),
				.step_second (step_second[g]),
				.clear_allow (clear_allow),
				.flag_clear  (flag_clear[g])
			);
		end
	endgenerate

endmodule

// ==== design/sys_integ_pkg.sv ====
package sys_integ_pkg;

	localparam int ADDR_W = 18;
	localparam int DATA_W = 32;
	localparam int REG_W  = 8;

	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_BREAK_STATUS = 16'hFE00;
	localparam logic [15:0] IDX_RESET_CAUSE  = 16'hFE01;
	localparam logic [15:0] IDX_BREAK_CTRL   = 16'hFE03;

	localparam logic [1:0] ADDR_LSB = 2'h0;
	localparam logic [ADDR_W-1:0] ADDR_BREAK_STATUS = {IDX_BREAK_STATUS, ADDR_LSB};
	localparam logic [ADDR_W-1:0] ADDR_RESET_CAUSE  = {IDX_RESET_CAUSE, ADDR_LSB};
	localparam logic [ADDR_W-1:0] ADDR_BREAK_CTRL   = {IDX_BREAK_CTRL, ADDR_LSB};

	// field positions
	localparam int BIT_BREAK_EXIT   = 0;
	localparam int BIT_BREAK_CLR_EN = 0;
	localparam int BIT_POR          = 5;
	localparam int BIT_PIN          = 4;
	localparam int BIT_WATCHDOG     = 3;
	localparam int BIT_ILL_OPCODE   = 2;
	localparam int BIT_ILL_ADDRESS  = 1;
	localparam int BIT_LOW_VOLTAGE  = 0;

	// reset values
	localparam logic [REG_W-1:0] RST_BREAK_STATUS = 8'h00;
	localparam logic [REG_W-1:0] RST_RESET_CAUSE  = 8'h20;
	localparam logic [REG_W-1:0] RST_BREAK_CTRL   = 8'h00;
	localparam logic [REG_W-1:0] REG_ZERO         = 8'h00;
	localparam logic [DATA_W-1:0] DATA_ZERO       = 32'h00000000;

	localparam int GUARD_CH = 2;

	typedef struct packed {
		logic pin;
		logic watchdog;
		logic illegal_opcode;
		logic illegal_address;
		logic address_is_fetch;
		logic low_voltage;
	} reset_src_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              write;
		logic [DATA_W-1:0] wdata;
	} apb_req_t;

	typedef enum logic [1:0] {
		SEL_NONE  = 2'b00,
		SEL_BREAK = 2'b01,
		SEL_CAUSE = 2'b10,
		SEL_CTRL  = 2'b11
	} reg_sel_t;

	typedef enum logic {
		GUARD_IDLE  = 1'b0,
		GUARD_ARMED = 1'b1
	} guard_state_t;

endpackage

// ==== design/two_step_clear_guard.sv ====
`timescale 1ns/1ns
module two_step_clear_guard (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic step_first,
	input  wire logic step_second,
	input  wire logic clear_allow,
	output logic      flag_clear
);
	import sys_integ_pkg::*;

	guard_state_t state;
	guard_state_t next_state;
	logic         next_flag_clear;

	// arming survives break so a pre-break first step still completes
	always_comb begin
		next_state = state;
		next_flag_clear = 1'b0;
		unique case (state)
			GUARD_IDLE: begin
				if (step_first) begin
					next_state = GUARD_ARMED;
				end
			end
			GUARD_ARMED: begin
				if (step_second && clear_allow) begin
					next_state = GUARD_IDLE;
					next_flag_clear = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= GUARD_IDLE;
			flag_clear <= 1'b0;
		end else begin
			state <= next_state;
			flag_clear <= next_flag_clear;
		end
	end

endmodule

// ==== testbench/reset_break_assertions.sv ====
`timescale 1ns/1ns
module reset_break_checker (
	input wire logic                                pclk,
	input wire logic                                presetn,
	input wire logic                                psel,
	input wire logic                                penable,
	input wire logic                                pwrite,
	input wire logic [sys_integ_pkg::ADDR_W-1:0]    paddr,
	input wire logic [sys_integ_pkg::DATA_W-1:0]    pwdata,
	input wire logic                                pready,
	input wire logic                                pslverr,
	input wire logic [sys_integ_pkg::DATA_W-1:0]    prdata,
	input wire sys_integ_pkg::reset_src_t           reset_src,
	input wire logic                                break_state,
	input wire logic                                break_clear_enable,
	input wire logic                                clear_allow,
	input wire logic [sys_integ_pkg::GUARD_CH-1:0]  step_second,
	input wire logic [sys_integ_pkg::GUARD_CH-1:0]  flag_clear
);
	import sys_integ_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable;
	wire hit = paddr == ADDR_BREAK_STATUS || paddr == ADDR_RESET_CAUSE
		|| paddr == ADDR_BREAK_CTRL;
	wire rd_cause = acc && !pwrite && paddr == ADDR_RESET_CAUSE;
	// a source pulse in either phase would legally refill the flags
	wire su_cause = psel && !penable && !pwrite
		&& paddr == ADDR_RESET_CAUSE && reset_src == '0;
	////////////////////////////////////////////////////////////////////////
	property p_ready; acc |-> pready; endproperty
	a_ready: assert property (p_ready)
		else $error("no ready");
	property p_unmapped; acc && !hit |-> pslverr && prdata == DATA_ZERO;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("bad unmapped");
	property p_mapped; acc && hit |-> !pslverr; endproperty
	a_mapped: assert property (p_mapped)
		else $error("error on mapped");
	property p_upper; acc |-> prdata[31:8] == 24'h000000; endproperty
	a_upper: assert property (p_upper)
		else $error("upper bits set");
	property p_allow; clear_allow == (!break_state || break_clear_enable);
	endproperty
	a_allow: assert property (p_allow)
		else $error("clear gate wrong");
	property p_ctrl; acc && pwrite && paddr == ADDR_BREAK_CTRL |=>
		break_clear_enable == $past(pwdata[BIT_BREAK_CLR_EN]); endproperty
	a_ctrl: assert property (p_ctrl)
		else $error("enable not written");
	property p_guard; |flag_clear |-> $past(clear_allow)
		&& (flag_clear & ~$past(step_second)) == '0; endproperty
	a_guard: assert property (p_guard)
		else $error("stray clear");
	property p_rc; su_cause ##1 rd_cause && clear_allow && reset_src == '0
		##1 !psel && reset_src == '0 ##1 su_cause |=> prdata[7:0] == REG_ZERO;
	endproperty
	a_rc: assert property (p_rc)
		else $error("cause not cleared");
endmodule
bind reset_and_break_status_regs reset_break_checker u_chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.prdata(prdata), .reset_src(reset_src), .break_state(break_state),
	.break_clear_enable(break_clear_enable), .clear_allow(clear_allow),
	.step_second(step_second), .flag_clear(flag_clear));

// ==== testbench/testbench.sv ====
`timescale 1ns/1ns
module testbench;
	import sys_integ_pkg::*;
	logic	pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
	logic	pwrite = 1'h0, break_exit_event = 1'h0, break_state = 1'h0;
	logic	pready, pslverr, break_clear_enable, clear_allow, err;
	logic [ADDR_W-1:0]	paddr = '0;
	logic [DATA_W-1:0]	pwdata = '0, prdata, rdat;
	reset_src_t	reset_src = '0;
	logic [GUARD_CH-1:0]	step_first = '0, step_second = '0, flag_clear;
	int	miscompares = 0, compares = 0, cyc = 0;
	localparam logic [ADDR_W-1:0] BS = ADDR_BREAK_STATUS;
	localparam logic [ADDR_W-1:0] RC = ADDR_RESET_CAUSE;
	localparam logic [ADDR_W-1:0] BC = ADDR_BREAK_CTRL;
	reset_and_break_status_regs dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.break_exit_event(break_exit_event), .reset_src(reset_src),
		.break_state(break_state), .break_clear_enable(break_clear_enable),
		.clear_allow(clear_allow), .step_first(step_first),
		.step_second(step_second), .flag_clear(flag_clear));
	initial forever #25 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 2000) begin
			miscompares++;
			summarize();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic summarize;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// idle cycle after each transfer: psel never driven twice in one step
	task automatic apb(input logic [ADDR_W-1:0] a, input logic w,
		input logic [31:0] d);
		psel <= 1'h1;
		penable <= 1'h0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rdat = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
		apb(a, 1'h0, DATA_ZERO);
		chk(rdat, exp);
	endtask
	task automatic cause(input reset_src_t s);
		reset_src <= s;
		@(posedge pclk);
		reset_src <= '0;
		@(posedge pclk);
	endtask
	task automatic brk;
		break_exit_event <= 1'h1;
		@(posedge pclk);
		break_exit_event <= 1'h0;
		@(posedge pclk);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rd(RC, 32'h20);
		rd(RC, 32'h0);
		rd(BS, 32'h0);
		rd(BC, 32'h0);
	endtask
	task automatic t_causes;
		reset_src_t src[6] = '{6'h20, 6'h10, 6'h08, 6'h06, 6'h01, 6'h04};
		logic [7:0] exp[6] = '{8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h00};
		for (int i = 0; i < 6; i++) begin
			cause(src[i]);
			rd(RC, {24'h0, exp[i]});
		end
	endtask
	task automatic t_break;
		brk();
		rd(BS, 32'h1);
		apb(BS, 1'h1, 32'hFE);
		rd(BS, 32'h0);
		brk();
		cause(6'h10);
		rd(BS, 32'h0);
		rd(RC, 32'h08);
	endtask
	task automatic t_ctrl;
		apb(BC, 1'h1, 32'hFFFFFFFF);
		rd(BC, 32'h1);
		break_state <= 1'h1;
		@(posedge pclk);
		chk({31'h0, clear_allow}, 32'h1);
		apb(BC, 1'h1, 32'h0);
		chk({31'h0, clear_allow}, 32'h0);
		brk();
		apb(BS, 1'h1, 32'h0);
		rd(BS, 32'h1);
		cause(6'h10);
		rd(RC, 32'h08);
		rd(RC, 32'h08);
		// software opens clearing before it clears anything in break
		apb(BC, 1'h1, 32'h1);
		brk();
		apb(BS, 1'h1, 32'h0);
		rd(BS, 32'h0);
		rd(RC, 32'h08);
		break_state <= 1'h0;
		@(posedge pclk);
		rd(BS, 32'h0);
		rd(RC, 32'h0);
	endtask
	// a second power-on reset mid-run must wipe every recorded cause
	task automatic t_por;
		apb(BC, 1'h1, 32'h1);
		cause(6'h20);
		brk();
		presetn <= 1'h0;
		@(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		rd(RC, 32'h20);
		rd(RC, 32'h0);
		rd(BS, 32'h0);
		rd(BC, 32'h0);
	endtask
	task automatic t_guard;
		apb(BC, 1'h1, 32'h0);
		step_first <= 2'h3;
		break_state <= 1'h1;
		@(posedge pclk);
		step_first <= 2'h0;
		step_second <= 2'h3;
		@(posedge pclk);
		step_second <= 2'h0;
		@(negedge pclk);
		chk({30'h0, flag_clear}, 32'h0);
		@(posedge pclk);
		break_state <= 1'h0;
		step_second <= 2'h3;
		@(posedge pclk);
		step_second <= 2'h0;
		@(negedge pclk);
		chk({30'h0, flag_clear}, 32'h3);
		@(posedge pclk);
	endtask
	task automatic t_unmapped;
		apb({16'hFE02, 2'h0}, 1'h0, DATA_ZERO);
		chk({31'h0, err}, 32'h1);
		chk(rdat, 32'h0);
		apb(RC, 1'h1, 32'hFF);
		rd(RC, 32'h0);
	endtask
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		t_reset();
		t_causes();
		t_break();
		t_ctrl();
		t_guard();
		t_unmapped();
		t_por();
		summarize();
	end
endmodule
